// file: design/strap_mux_pkg.sv
// shared constants and carrier types for the strap capture and pin mux
// Operation
// - Mode straps are read once, at the first clock edge after reset release; afterwards they act as flag pins.
// - Memory mode comes from the mode strap and never changes while running.
// - Mode strap 0: drive 14 address pins, use 24 data pins.
// - Full memory mode: byte accesses put byte address on 8 top data pins.
// - Mode strap 1: 16-bit host address/data bus with strobes and acknowledge.
// - Host mode: one address pin and upper 16 data pins serve all spaces.
// - Bus request answered by grant, plus hung output when grant stalls core.
// - Interrupt-shared flag pins raise interrupt whether driven outside or as output.
package strap_mux_pkg;
    localparam int ADDR_W       = 14;
    localparam int DATA_W       = 24;
    localparam int HOST_W       = 16;
    localparam int BYTE_ADDR_W  = 8;
    localparam int FLAG_N       = 8;
    localparam int UPPER_LO     = 8;
    localparam int IRQ_FLAG_LO  = 4;
    localparam int IRQ_N        = 4;
    localparam int STRAP_A_POS  = 0;
    localparam int STRAP_B_POS  = 1;
    localparam int STRAP_C_POS  = 2;
    localparam int STRAP_N      = 3;
    localparam logic [STRAP_N-1:0] STRAP_RST = 3'h0;

    typedef enum logic {MODE_FULL, MODE_HOST} mem_mode_e;
    typedef enum logic {PH_ARM, PH_RUN} phase_e;

    // core request toward the external memory bus
    typedef struct packed {
        logic                   active;
        logic                   write;
        logic                   byte_access;
        logic [ADDR_W-1:0]      addr;
        logic [BYTE_ADDR_W-1:0] byte_addr;
        logic [DATA_W-1:0]      wdata;
    } mem_req_s;

    // external memory bus pin drive
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data_out;
        logic [DATA_W-1:0] data_oe_n;
    } mem_pins_s;

    // host port strobes as seen by the core
    typedef struct packed {
        logic write;
        logic read;
        logic latch;
        logic select;
    } host_strobe_s;
endpackage

// file: design/flag_pin_cell.sv
// one programmable flag pin with registered drive and sensed level
`timescale 1ns/10ps
module flag_pin_cell
    import strap_mux_pkg::*;
(
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_reset_n,
    // core side
    input  wire logic i_enable,
    input  wire logic i_drive,
    input  wire logic i_value,
    output logic      o_level,
    // pin
    input  wire logic i_pin_in,
    output logic      o_pin_out,
    output logic      o_pin_oe_n
);
    typedef struct packed {
        logic pin_out;
        logic oe_n;
        logic level;
    } cell_s;

    cell_s st_r;
    cell_s st_nxt;

    always_comb begin
        st_nxt         = st_r;
        st_nxt.pin_out = i_value;
        st_nxt.oe_n    = !(i_enable && i_drive);
        // own drive counts as the level so an output flag still interrupts
        st_nxt.level   = st_r.oe_n ? i_pin_in : st_r.pin_out;
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_r <= '{pin_out: 1'b0, oe_n: 1'b1, level: 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_pin_out  = st_r.pin_out;
    assign o_pin_oe_n = st_r.oe_n;
    assign o_level    = st_r.level;
endmodule

// file: design/reset_mode_strap_pin_mux.sv
// strap capture at reset release and external/host pin multiplexing
`timescale 1ns/10ps
module reset_mode_strap_pin_mux
    import strap_mux_pkg::*;
(
    // clock and reset
    input  wire logic                 i_clk,
    input  wire logic                 i_reset_n,
    // core: memory bus
    input  wire mem_req_s             i_mem_req,
    output logic [DATA_W-1:0]         o_mem_rdata,
    // core: flags
    input  wire logic [FLAG_N-1:0]    i_flag_drive,
    input  wire logic [FLAG_N-1:0]    i_flag_value,
    output logic [FLAG_N-1:0]         o_flag_level,
    output logic [IRQ_N-1:0]          o_irq_req,
    // core: host port side
    input  wire logic [HOST_W-1:0]    i_host_rdata,
    input  wire logic                 i_host_ready,
    output host_strobe_s              o_host_strobe,
    output logic [HOST_W-1:0]         o_host_wdata,
    // core: bus arbitration
    input  wire logic                 i_core_bus_idle,
    input  wire logic                 i_core_ext_wait,
    // mode state
    output logic                      o_mode_valid,
    output mem_mode_e                 o_mem_mode,
    output logic [STRAP_N-1:0]        o_straps,
    // flag pins, low three carry the mode straps during reset
    input  wire logic [FLAG_N-1:0]    i_flag_pin_in,
    output logic [FLAG_N-1:0]         o_flag_pin_out,
    output logic [FLAG_N-1:0]         o_flag_pin_oe_n,
    // external memory pins
    output mem_pins_s                 o_ext_pins,
    input  wire logic [DATA_W-1:0]    i_ext_data_in,
    // host port pins
    input  wire logic [HOST_W-1:0]    i_host_addr_data_bus_in,
    output logic [HOST_W-1:0]         o_host_addr_data_bus_out,
    output logic [HOST_W-1:0]         o_host_addr_data_bus_oe_n,
    input  wire logic                 i_host_write_strobe_n,
    input  wire logic                 i_host_read_strobe_n,
    input  wire logic                 i_host_addr_latch,
    input  wire logic                 i_host_port_select_n,
    output logic                      o_host_port_ack_n,
    // bus arbitration pins
    input  wire logic                 i_bus_request_in_n,
    output logic                      o_bus_grant_out_n,
    output logic                      o_bus_grant_hung_out_n
);
    typedef struct packed {
        phase_e                   phase;
        mem_mode_e                mode;
        logic [STRAP_N-1:0]       straps;
        mem_pins_s                pins;
        logic [DATA_W-1:0]        rdata;
        logic [HOST_W-1:0]        host_out;
        logic [HOST_W-1:0]        host_oe_n;
        logic [HOST_W-1:0]        host_wdata;
        host_strobe_s             strobe;
        logic                     ack_n;
        logic                     grant_n;
        logic                     hung_n;
        logic [IRQ_N-1:0]         irq;
    } mux_s;

    mux_s st_r;
    mux_s st_nxt;

    logic [FLAG_N-1:0] flag_enable;
    logic              host_sel;
    logic              granted;

    // straps stay undriven until captured so the strap level is readable
    assign flag_enable = {FLAG_N{st_r.phase == PH_RUN}};

    genvar g;
    generate
        for (g = 0; g < FLAG_N; g++) begin : g_flag
            flag_pin_cell u_cell (
                .i_clk      (i_clk),
                .i_reset_n  (i_reset_n),
                .i_enable   (flag_enable[g]),
                .i_drive    (i_flag_drive[g]),
                .i_value    (i_flag_value[g]),
                .o_level    (o_flag_level[g]),
                .i_pin_in   (i_flag_pin_in[g]),
                .o_pin_out  (o_flag_pin_out[g]),
                .o_pin_oe_n (o_flag_pin_oe_n[g])
            );
        end
    endgenerate

    assign host_sel = (st_r.mode == MODE_HOST) && (st_r.phase == PH_RUN)
                      && !i_host_port_select_n;
    assign granted  = !st_r.grant_n;

    always_comb begin
        st_nxt = st_r;
        // single capture at the first edge after reset release
        if (st_r.phase == PH_ARM) begin
            st_nxt.phase  = PH_RUN;
            st_nxt.straps = i_flag_pin_in[STRAP_N-1:0];
            st_nxt.mode   = i_flag_pin_in[STRAP_C_POS] ? MODE_HOST
                                                       : MODE_FULL;
        end

        // bus arbitration: grant only once core lets go of the bus
        st_nxt.grant_n = !(!i_bus_request_in_n && st_r.phase == PH_RUN
                           && (granted || i_core_bus_idle));
        st_nxt.hung_n  = !(granted && !i_bus_request_in_n
                           && i_core_ext_wait);

        // external memory bus, released while granted or before capture
        st_nxt.pins.addr      = '0;
        st_nxt.pins.data_out  = '0;
        st_nxt.pins.data_oe_n = '1;
        if (st_r.phase == PH_RUN && !granted && i_mem_req.active) begin
            unique case (st_r.mode)
                MODE_FULL: begin
                    st_nxt.pins.addr = i_mem_req.addr;
                    if (i_mem_req.write) begin
                        st_nxt.pins.data_out  = i_mem_req.wdata;
                        st_nxt.pins.data_oe_n = '0;
                    end
                    if (i_mem_req.byte_access) begin
                        st_nxt.pins.data_out[DATA_W-1 -: BYTE_ADDR_W] =
                            i_mem_req.byte_addr;
                        st_nxt.pins.data_oe_n[DATA_W-1 -: BYTE_ADDR_W] =
                            '0;
                    end
                end
                MODE_HOST: begin
                    // only the lowest address bit leaves the chip here
                    st_nxt.pins.addr[0] = i_mem_req.addr[0];
                    if (i_mem_req.write) begin
                        st_nxt.pins.data_out[DATA_W-1:UPPER_LO] =
                            i_mem_req.wdata[DATA_W-1:UPPER_LO];
                        st_nxt.pins.data_oe_n[DATA_W-1:UPPER_LO] = '0;
                    end
                end
            endcase
        end
        st_nxt.rdata = i_ext_data_in;
        if (st_r.mode == MODE_HOST) begin
            st_nxt.rdata[UPPER_LO-1:0] = '0;
        end

        // host port, dead in full memory mode
        st_nxt.strobe.select = host_sel;
        st_nxt.strobe.write  = host_sel && !i_host_write_strobe_n;
        st_nxt.strobe.read   = host_sel && !i_host_read_strobe_n;
        st_nxt.strobe.latch  = (st_r.mode == MODE_HOST)
                               && (st_r.phase == PH_RUN) && i_host_addr_latch;
        st_nxt.host_wdata    = i_host_addr_data_bus_in;
        st_nxt.ack_n         = !(host_sel && i_host_ready);
        st_nxt.host_out      = i_host_rdata;
        st_nxt.host_oe_n     = {HOST_W{!(host_sel
                                && !i_host_read_strobe_n)}};

        // interrupt inputs are active low on the shared pins
        st_nxt.irq = ~o_flag_level[IRQ_FLAG_LO +: IRQ_N];
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_r                <= '0;
            st_r.phase          <= PH_ARM;
            st_r.mode           <= MODE_FULL;
            st_r.straps         <= STRAP_RST;
            st_r.pins.data_oe_n <= '1;
            st_r.host_oe_n      <= '1;
            st_r.ack_n          <= 1'b1;
            st_r.grant_n        <= 1'b1;
            st_r.hung_n         <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_mode_valid              = (st_r.phase == PH_RUN);
    assign o_mem_mode                = st_r.mode;
    assign o_straps                  = st_r.straps;
    assign o_ext_pins                = st_r.pins;
    assign o_mem_rdata               = st_r.rdata;
    assign o_host_strobe             = st_r.strobe;
    assign o_host_wdata              = st_r.host_wdata;
    assign o_host_addr_data_bus_out  = st_r.host_out;
    assign o_host_addr_data_bus_oe_n = st_r.host_oe_n;
    assign o_host_port_ack_n         = st_r.ack_n;
    assign o_bus_grant_out_n         = st_r.grant_n;
    assign o_bus_grant_hung_out_n    = st_r.hung_n;
    assign o_irq_req                 = st_r.irq;

    property p_strap_capture;
        @(posedge i_clk) disable iff (!i_reset_n)
        st_r.phase == PH_ARM |=>
            o_straps == $past(i_flag_pin_in[STRAP_N-1:0]);
    endproperty
    a_strap_capture: assert property (p_strap_capture)
        else $error("straps not captured at reset release");

    property p_no_drive_before_run;
        @(posedge i_clk) disable iff (!i_reset_n)
        st_r.phase == PH_ARM |-> &o_flag_pin_oe_n[STRAP_N-1:0];
    endproperty
    a_no_drive_before_run: assert property (p_no_drive_before_run)
        else $error("strap pins driven before capture");

    property p_mode_fixed;
        @(posedge i_clk) disable iff (!i_reset_n)
        o_mode_valid && $past(o_mode_valid) |-> $stable(o_mem_mode);
    endproperty
    a_mode_fixed: assert property (p_mode_fixed)
        else $error("memory mode changed while running");

    property p_mode_from_strap;
        @(posedge i_clk) disable iff (!i_reset_n)
        o_mode_valid |->
            (o_mem_mode == MODE_HOST) == o_straps[STRAP_C_POS];
    endproperty
    a_mode_from_strap: assert property (p_mode_from_strap)
        else $error("mode does not match latched strap");

    property p_full_addr;
        @(posedge i_clk) disable iff (!i_reset_n)
        o_mode_valid && o_mem_mode == MODE_FULL && !granted
            && i_mem_req.active |=> o_ext_pins.addr == $past(i_mem_req.addr);
    endproperty
    a_full_addr: assert property (p_full_addr)
        else $error("full mode address not driven");

    property p_byte_addr;
        @(posedge i_clk) disable iff (!i_reset_n)
        o_mode_valid && o_mem_mode == MODE_FULL && !granted
            && i_mem_req.active && i_mem_req.byte_access |=>
            o_ext_pins.data_out[DATA_W-1 -: BYTE_ADDR_W]
                == $past(i_mem_req.byte_addr);
    endproperty
    a_byte_addr: assert property (p_byte_addr)
        else $error("byte address missing on top data pins");

    property p_host_reduced;
        @(posedge i_clk) disable iff (!i_reset_n)
        o_mem_mode == MODE_HOST |->
            o_ext_pins.addr[ADDR_W-1:1] == '0
            && &o_ext_pins.data_oe_n[UPPER_LO-1:0];
    endproperty
    a_host_reduced: assert property (p_host_reduced)
        else $error("host mode drives unused memory pins");

    property p_host_dead_full;
        @(posedge i_clk) disable iff (!i_reset_n)
        o_mem_mode == MODE_FULL |-> o_host_port_ack_n
            && &o_host_addr_data_bus_oe_n;
    endproperty
    a_host_dead_full: assert property (p_host_dead_full)
        else $error("host port active in full memory mode");

    property p_grant_release;
        @(posedge i_clk) disable iff (!i_reset_n)
        !o_bus_grant_out_n |-> &o_ext_pins.data_oe_n
            or $past(o_bus_grant_out_n);
    endproperty
    a_grant_release: assert property (p_grant_release)
        else $error("memory bus driven while granted");

    property p_hung_needs_grant;
        @(posedge i_clk) disable iff (!i_reset_n)
        !o_bus_grant_hung_out_n |-> !$past(o_bus_grant_out_n);
    endproperty
    a_hung_needs_grant: assert property (p_hung_needs_grant)
        else $error("hung asserted without grant");
endmodule

// file: verification/far_side_model.sv
// far-side model: strap pulls, flag levels, memory data and host bus
`timescale 1ns/10ps
module far_side_model
    import strap_mux_pkg::*;
(
    // clock
    input  wire logic               i_clk,
    // board side levels
    input  wire logic [STRAP_N-1:0] i_strap_pull,
    input  wire logic [FLAG_N-1:0]  i_flag_ext,
    input  wire logic [DATA_W-1:0]  i_mem_data,
    input  wire logic               i_host_drive,
    input  wire logic [HOST_W-1:0]  i_host_value,
    // device pins
    input  wire logic [FLAG_N-1:0]  i_flag_out,
    input  wire logic [FLAG_N-1:0]  i_flag_oe_n,
    input  wire mem_pins_s          i_ext_pins,
    input  wire logic [HOST_W-1:0]  i_bus_out,
    input  wire logic [HOST_W-1:0]  i_bus_oe_n,
    // resolved wire levels
    output logic [FLAG_N-1:0]       o_flag_in,
    output logic [DATA_W-1:0]       o_ext_data,
    output logic [HOST_W-1:0]       o_bus_in
);
    logic [HOST_W-1:0] bus_last_r = '0;
    logic [HOST_W-1:0] host_lvl;
    logic [FLAG_N-1:0] board_lvl;
    // straps by pull resistor, never fighting a flag output after reset
    assign board_lvl = {i_flag_ext[FLAG_N-1:STRAP_N], i_strap_pull};
    assign o_flag_in = (i_flag_out & ~i_flag_oe_n) | (board_lvl & i_flag_oe_n);
    // space selects sit outside this block; host mode decodes on addr[0]
    assign o_ext_data = (i_ext_pins.data_out & ~i_ext_pins.data_oe_n)
                      | (i_mem_data & i_ext_pins.data_oe_n);
    // released bus shows inverted last value so stale data cannot match
    assign host_lvl = i_host_drive ? i_host_value : ~bus_last_r;
    assign o_bus_in = (i_bus_out & ~i_bus_oe_n) | (host_lvl & i_bus_oe_n);
    always @(posedge i_clk) bus_last_r <= o_bus_in;
endmodule

// file: verification/tb_reset_mode_strap_pin_mux.sv
// self-checking bench for strap capture and pin multiplexing
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
module tb_reset_mode_strap_pin_mux
    import strap_mux_pkg::*;
;
    logic clk, rst_n, rdy, idle, ewait, wr_n, rd_n, al, sel_n, ack_n;
    logic br_n, bg_n, bgh_n, mvalid, hdrv, host;
    mem_req_s req;
    mem_pins_s pins, pe;
    host_strobe_s hstb;
    mem_mode_e mode;
    logic [2:0] straps, pull;
    logic [DATA_W-1:0] mrd, din, mdat;
    logic [FLAG_N-1:0] fdrv, fval, flev, fin, fout, foe_n, fext;
    logic [IRQ_N-1:0] irq;
    logic [HOST_W-1:0] hrd, hwd, hin, hout, hoe_n, hval;
    int n_errors, n_compared;

    reset_mode_strap_pin_mux u_reset_mode_strap_pin_mux (
        .i_clk(clk), .i_reset_n(rst_n), .i_mem_req(req), .o_mem_rdata(mrd),
        .i_flag_drive(fdrv), .i_flag_value(fval), .o_flag_level(flev),
        .o_irq_req(irq), .i_host_rdata(hrd), .i_host_ready(rdy),
        .o_host_strobe(hstb), .o_host_wdata(hwd), .i_core_bus_idle(idle),
        .i_core_ext_wait(ewait), .o_mode_valid(mvalid), .o_mem_mode(mode),
        .o_straps(straps), .i_flag_pin_in(fin), .o_flag_pin_out(fout),
        .o_flag_pin_oe_n(foe_n), .o_ext_pins(pins), .i_ext_data_in(din),
        .i_host_addr_data_bus_in(hin), .o_host_addr_data_bus_out(hout),
        .o_host_addr_data_bus_oe_n(hoe_n), .i_host_write_strobe_n(wr_n),
        .i_host_read_strobe_n(rd_n), .i_host_addr_latch(al),
        .i_host_port_select_n(sel_n), .o_host_port_ack_n(ack_n),
        .i_bus_request_in_n(br_n), .o_bus_grant_out_n(bg_n),
        .o_bus_grant_hung_out_n(bgh_n));

    far_side_model u_far_side_model (
        .i_clk(clk), .i_strap_pull(pull), .i_flag_ext(fext),
        .i_mem_data(mdat), .i_host_drive(hdrv), .i_host_value(hval),
        .i_flag_out(fout), .i_flag_oe_n(foe_n), .i_ext_pins(pins),
        .i_bus_out(hout), .i_bus_oe_n(hoe_n), .o_flag_in(fin),
        .o_ext_data(din), .o_bus_in(hin));

    function automatic mem_pins_s pin_exp(mem_req_s r, logic h);
        pin_exp.addr = h ? {13'h0, r.addr[0]} : r.addr;
        pin_exp.data_out = r.write ? r.wdata : 24'h000000;
        pin_exp.data_oe_n = r.write ? 24'h000000 : 24'hffffff;
        if (h) begin
            pin_exp.data_out[7:0] = 8'h00;
            pin_exp.data_oe_n[7:0] = 8'hff;
        end else if (r.byte_access) begin
            pin_exp.data_out[23:16] = r.byte_addr;
            pin_exp.data_oe_n[23:16] = 8'h00;
        end
    endfunction

    task automatic wait_chk(int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic do_reset(logic [2:0] s);
        @(posedge clk) rst_n <= 1'b0;
        pull <= s;
        wait_chk(0);
        `CHK({foe_n, hoe_n, pins.data_oe_n}, {FLAG_N + 40{1'b1}})
        `CHK({ack_n, bg_n, bgh_n, mvalid}, 4'he)
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        wait_chk(1);
        `CHK({mvalid, straps, mode}, {1'b1, s, s[2]})
        // board level flips after capture; the mode must not follow it
        @(posedge clk) pull <= ~s;
        wait_chk(3);
        `CHK({straps, mode}, {s, s[2]})
    endtask

    task automatic mem_tests();
        mem_req_s r;
        logic [7:0] top;
        for (int i = 0; i < 6; i++) begin
            r = mem_req_s'({$urandom, $urandom});
            r.active = 1'b1;
            r.byte_access = host ? 1'b0 : (i < 2) ? 1'b1 : r.byte_access;
            r.write = (i == 1) ? 1'b0 : r.write;
            pe = pin_exp(r, host);
            top = r.byte_access ? r.byte_addr
                                : r.write ? r.wdata[23:16] : 8'h00;
            @(posedge clk) req <= r;
            mdat <= DATA_W'($urandom);
            // pins are registered, so they show the request one edge on
            wait_chk(1);
            if (host) begin
                `CHK(pins.addr, pe.addr)
                `CHK(pins.data_out, pe.data_out)
                `CHK(pins.data_oe_n, pe.data_oe_n)
            end else begin
                `CHK(pins, pe)
                `CHK(pins.data_out[23:16], top)
            end
            @(posedge clk) req.active <= 1'b0;
            wait_chk(0);
            if (!r.write && host)
                `CHK(mrd, {mdat[23:8], 8'h00})
            else if (!r.write)
                `CHK(mrd, r.byte_access ? {top, mdat[15:0]} : mdat)
        end
    endtask

    task automatic host_tests();
        logic [3:0] s;
        for (int i = 0; i < 3; i++) begin
            s = (i == 0) ? 4'b1001 : (i == 1) ? 4'b0101 : 4'b0011;
            @(posedge clk) {wr_n, rd_n, sel_n} <= ~{s[3], s[2], s[0]};
            al <= s[1];
            rdy <= i[0] | i[1];
            hrd <= HOST_W'($urandom);
            hval <= HOST_W'($urandom);
            hdrv <= s[3];
            wait_chk(1);
            `CHK(hstb, host ? host_strobe_s'(s) : host_strobe_s'(4'h0))
            `CHK(ack_n, ~(host & rdy))
            `CHK(hoe_n, (host & s[2]) ? 16'h0000 : 16'hffff)
            if (host && s[2])
                `CHK(hout, hrd)
            if (host && s[3])
                `CHK(hwd, hval)
            @(posedge clk) {wr_n, rd_n, sel_n, al, hdrv} <= 5'h1c;
        end
    endtask

    task automatic misc_tests();
        logic [FLAG_N-1:0] lev;
        @(posedge clk) fdrv <= FLAG_N'($urandom);
        fval <= FLAG_N'($urandom);
        fext <= FLAG_N'($urandom);
        wait_chk(1);
        `CHK(foe_n, ~fdrv)
        `CHK(fout & fdrv, fval & fdrv)
        lev = (fval & fdrv) | ({fext[7:3], pull} & ~fdrv);
        wait_chk(2);
        `CHK(flev, lev)
        `CHK(irq, ~lev[7:4])
        @(posedge clk) br_n <= 1'b0;
        idle <= 1'b0;
        wait_chk(2);
        `CHK(bg_n, 1'b1)
        @(posedge clk) idle <= 1'b1;
        req.active <= 1'b1;
        // grant lands one edge on, the memory bus lets go one edge later
        wait_chk(1);
        `CHK(bg_n, 1'b0)
        wait_chk(1);
        `CHK({bg_n, pins.addr, pins.data_oe_n}, {15'h0, 24'hffffff})
        @(posedge clk) ewait <= 1'b1;
        idle <= 1'b0;
        wait_chk(1);
        `CHK({bg_n, bgh_n}, 2'b00)
        @(posedge clk) {br_n, ewait, req.active} <= 3'b100;
        wait_chk(1);
        `CHK({bg_n, bgh_n}, 2'b11)
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        // a clean run needs a few hundred cycles; this leaves wide margin
        repeat (4000) @(posedge clk);
        n_errors++;
        wrap_up();
    end

    initial begin
        logic [2:0] s;
        {rst_n, rdy, idle, ewait, al, hdrv} = '0;
        {wr_n, rd_n, sel_n, br_n} = '1;
        {req, mdat, fdrv, fval, fext, hrd, hval, pull} = '0;
        n_errors = 0;
        n_compared = 0;
        void'($urandom(32'h1586));
        for (int k = 0; k < 5; k++) begin
            s = (k == 0) ? 3'h0 : (k == 1) ? 3'h7 : 3'($urandom);
            host = s[2];
            do_reset(s);
            mem_tests();
            host_tests();
            misc_tests();
        end
        wrap_up();
    end
endmodule
